// *** crs_pkg.sv ***
// Package for the core register set: widths, stack page codes, operation codes.
// Assumes a single system clock and an instruction decoder driving the op port.
package crs_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 16;
   // Core mode register location and stack page select bit position
   localparam logic [15:0] CORE_MODE_ADDR = 16'h003b;
   localparam int unsigned CORE_MODE_STACK_PAGE_BIT = 2;
   localparam logic [7:0] CORE_MODE_RESET = 8'h00;
   // Stack page upper bytes
   localparam logic [7:0] STACK_PAGE0_HIGH = 8'h00;
   localparam logic [7:0] STACK_PAGE1_HIGH = 8'h01;
   // Reset values (not given; plain defaults)
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] INDEX_RESET = 8'h00;
   localparam logic [7:0] SP_RESET = 8'hff;
   localparam logic [15:0] PC_RESET = 16'h0000;
   // Register select for direct loads
   localparam logic [2:0] SEL_ACC = 3'h0;
   localparam logic [2:0] SEL_IDX1 = 3'h1;
   localparam logic [2:0] SEL_IDX2 = 3'h2;
   localparam logic [2:0] SEL_SP = 3'h3;
   localparam logic [2:0] SEL_PC_LOW = 3'h4;
   localparam logic [2:0] SEL_PC_HIGH = 3'h5;
   // Instruction family opcodes used for the supported-instruction check
   localparam logic [7:0] OPC_FAST_SET = 8'he2;
   localparam logic [7:0] OPC_SLOW_CLOCK = 8'hc2;
   localparam logic [7:0] OPC_STOP_OSC = 8'h42;
   localparam logic [7:0] OPC_WAIT = 8'hd2;
   localparam logic [7:0] OPC_MULTIPLY = 8'h62;
   localparam logic [7:0] OPC_DIVIDE = 8'hf2;
   // Stack operations
   typedef enum logic [4:0] {
      CRS_STK_IDLE = 5'b00001,
      CRS_STK_PUSH_ACC = 5'b00010,
      CRS_STK_POP_ACC = 5'b00100,
      CRS_STK_PUSH_STAT = 5'b01000,
      CRS_STK_POP_STAT = 5'b10000
   } crs_stack_op_t;
endpackage : crs_pkg

// *** crs_register_set.sv ***
// Programmer-visible register set: working register, two index registers,
// stack pointer with page select, and program counter with stack/index
// address generation. Assumes memory answers reads in the same cycle.
`timescale 1ns/1ps

// Summary of operation
// - One 8-bit working register for data
// - Indexed address is operand plus first index
// - Second-index address is operand plus second index
// - 8-bit stack pointer for calls, interrupts
// - Stack low byte is stack pointer, plus one for a pop
// - Stack high byte 00 or 01 by page
// - Program counter is two 8-bit halves
// - Program counter points at next fetch
// - Fast-set and slow-clock instructions flagged unsupported
// - Stop, wait, multiply, divide are supported
// - Push and pop for working, status registers
// - Page bit lives in core mode register
module crs_register_set (
   // Clock, reset, enable
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   // Instruction decoder controls
   input wire logic [7:0] operand_in,
   input wire logic [7:0] opcode_in,
   input wire logic pc_advance_in,
   input wire logic pc_load_in,
   input wire logic [15:0] pc_load_value_in,
   input wire logic reg_write_in,
   input wire logic [2:0] reg_sel_in,
   input wire logic [7:0] reg_write_data_in,
   input wire crs_pkg::crs_stack_op_t stack_op_in,
   input wire logic [7:0] status_in,
   // Data memory bus (single cycle)
   input wire logic [15:0] mem_addr_in,
   input wire logic mem_write_in,
   input wire logic [7:0] mem_wdata_in,
   input wire logic [7:0] mem_rdata_in,
   // Register outputs
   output logic [7:0] accumulator_out,
   output logic [7:0] index_first_out,
   output logic [7:0] index_second_out,
   output logic [7:0] stack_pointer_out,
   output logic [15:0] program_counter_out,
   output logic [7:0] core_mode_register_out,
   // Address generation
   output logic [15:0] index_first_addr_out,
   output logic [15:0] index_second_addr_out,
   output logic [15:0] stack_addr_out,
   // Stack memory port
   output logic stack_write_out,
   output logic stack_read_out,
   output logic [7:0] stack_wdata_out,
   output logic [7:0] status_pop_out,
   output logic status_pop_valid_out,
   // Instruction support check
   output logic instr_supported_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset synchroniser
   // Release is delayed two edges so no flip-flop leaves reset on a metastable edge
   logic rst_meta_reg;
   logic rst_sync_n_reg;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n_reg <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   // All state below is frozen whenever the clock enable is low
   // Working and index registers
   logic [7:0] acc_reg;
   logic [7:0] idx1_reg;
   logic [7:0] idx2_reg;

   // Stack pointer and its post-pop value
   logic [7:0] sp_reg;
   logic [7:0] sp_next;

   // Program counter halves, held apart so each can be loaded alone
   logic [7:0] pc_high_reg;
   logic [7:0] pc_low_reg;

   // Core mode register; only the stack page bit is used here
   logic [7:0] core_mode_reg;

   // Popped status byte and its one-cycle marker
   logic [7:0] status_pop_reg;
   logic status_pop_valid_reg;

   // Decoded stack operations
   logic is_push;
   logic is_pop;
   logic is_pop_acc;
   logic is_pop_stat;
   logic is_push_stat;

   // Decoded direct loads, one per destination
   logic wr_acc;
   logic wr_idx1;
   logic wr_idx2;
   logic wr_sp;
   logic wr_pc_low;
   logic wr_pc_high;

   // Operand plus an index, zero extended to a 16-bit address
   // The 9-bit sum keeps the carry, so an index never wraps inside a page
   function automatic logic [15:0] crs_index_addr(input logic [7:0] opnd,
                                                  input logic [7:0] idx);
      logic [8:0] sum;
      sum = {1'b0, opnd} + {1'b0, idx};
      return {7'h00, sum};
   endfunction : crs_index_addr

   // Direct-load decode, shared by every destination register
   function automatic logic crs_sel_hit(input logic wr,
                                        input logic [2:0] sel,
                                        input logic [2:0] target);
      return wr && (sel == target);
   endfunction : crs_sel_hit

   // Stack operation decode; the one-hot code makes each test a plain compare
   assign is_push = (stack_op_in == crs_pkg::CRS_STK_PUSH_ACC) ||
                    (stack_op_in == crs_pkg::CRS_STK_PUSH_STAT);
   assign is_pop = (stack_op_in == crs_pkg::CRS_STK_POP_ACC) ||
                   (stack_op_in == crs_pkg::CRS_STK_POP_STAT);
   assign is_pop_acc = (stack_op_in == crs_pkg::CRS_STK_POP_ACC);
   assign is_pop_stat = (stack_op_in == crs_pkg::CRS_STK_POP_STAT);
   assign is_push_stat = (stack_op_in == crs_pkg::CRS_STK_PUSH_STAT);

   // Direct loads; stack and flow changes outrank these further down
   assign wr_acc = crs_sel_hit(reg_write_in, reg_sel_in, crs_pkg::SEL_ACC);
   assign wr_idx1 = crs_sel_hit(reg_write_in, reg_sel_in, crs_pkg::SEL_IDX1);
   assign wr_idx2 = crs_sel_hit(reg_write_in, reg_sel_in, crs_pkg::SEL_IDX2);
   assign wr_sp = crs_sel_hit(reg_write_in, reg_sel_in, crs_pkg::SEL_SP);
   assign wr_pc_low = crs_sel_hit(reg_write_in, reg_sel_in, crs_pkg::SEL_PC_LOW);
   assign wr_pc_high = crs_sel_hit(reg_write_in, reg_sel_in, crs_pkg::SEL_PC_HIGH);

   ////////////////////////////////////////////////////////////////////////////
   // Address generation
   // Both sums are combinational so the address is ready in the same cycle
   // first index sum
   assign index_first_addr_out = crs_index_addr(operand_in, idx1_reg);
   assign index_second_addr_out = crs_index_addr(operand_in, idx2_reg);

   assign sp_next = is_pop ? sp_reg + 8'h01 : sp_reg;

   // Pushes use the pointer as is, pops the incremented copy
   // stack page and low byte
   assign stack_addr_out = {(core_mode_reg[crs_pkg::CORE_MODE_STACK_PAGE_BIT] ?
                             crs_pkg::STACK_PAGE1_HIGH : crs_pkg::STACK_PAGE0_HIGH),
                            sp_next};

   // Stack strobes: push writes this cycle; pop reads this cycle at sp+1
   // Strobes are gated by the enable so a frozen core never touches memory
   // Read data must arrive in the same cycle; there is no wait state
   // A status push sends the outside status byte, never the working register
   // push and pop strobes
   assign stack_write_out = is_push && clk_en_in;
   assign stack_read_out = is_pop && clk_en_in;
   assign stack_wdata_out = is_push_stat ? status_in : acc_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Working register
   // A pop outranks a direct load aimed at the same register
   // working register update
   always_ff @(posedge core_clk_in or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         acc_reg <= crs_pkg::ACC_RESET;
      end else if (clk_en_in) begin
         if (is_pop_acc) begin
            acc_reg <= mem_rdata_in;
         end else if (wr_acc) begin
            acc_reg <= reg_write_data_in;
         end
      end
   end

   // Index registers; only direct loads change them
   // Their sums feed the address outputs combinationally
   always_ff @(posedge core_clk_in or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         idx1_reg <= crs_pkg::INDEX_RESET;
         idx2_reg <= crs_pkg::INDEX_RESET;
      end else if (clk_en_in) begin
         if (wr_idx1) begin
            idx1_reg <= reg_write_data_in;
         end
         if (wr_idx2) begin
            idx2_reg <= reg_write_data_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stack pointer; a push or pop takes priority over a direct load
   // Reset leaves it at the top of the page, so the first push lands there
   // The pointer wraps within its page; software must not overrun the stack
   // pointer adjust
   always_ff @(posedge core_clk_in or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         sp_reg <= crs_pkg::SP_RESET;
      end else if (clk_en_in) begin
         if (is_push) begin
            sp_reg <= sp_reg - 8'h01;
         end else if (is_pop) begin
            sp_reg <= sp_next;
         end else if (wr_sp) begin
            sp_reg <= reg_write_data_in;
         end
      end
   end

   // Popped status byte, held for the status flag logic outside
   // The marker lasts one enabled cycle; the byte stays until the next status pop
   // Registering the byte costs a cycle but keeps the output glitch free
   // status pop capture
   always_ff @(posedge core_clk_in or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         status_pop_reg <= 8'h00;
         status_pop_valid_reg <= 1'b0;
      end else if (clk_en_in) begin
         status_pop_valid_reg <= is_pop_stat;
         if (is_pop_stat) begin
            status_pop_reg <= mem_rdata_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core mode register, written through the memory bus at its fixed address
   // All eight bits are writable; the clock control bits are kept for outside use
   // core mode write
   always_ff @(posedge core_clk_in or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         core_mode_reg <= crs_pkg::CORE_MODE_RESET;
      end else if (clk_en_in && mem_write_in && mem_addr_in == crs_pkg::CORE_MODE_ADDR) begin
         core_mode_reg <= mem_wdata_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter halves; a load beats an advance so flow changes win
   // A half load drops an advance in the same cycle; the decoder must not ask both
   // The counter wraps from the top of memory back to zero
   // counter update
   always_ff @(posedge core_clk_in or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         pc_high_reg <= crs_pkg::PC_RESET[15:8];
         pc_low_reg <= crs_pkg::PC_RESET[7:0];
      end else if (clk_en_in) begin
         if (pc_load_in) begin
            pc_high_reg <= pc_load_value_in[15:8];
            pc_low_reg <= pc_load_value_in[7:0];
         end else if (wr_pc_low) begin
            pc_low_reg <= reg_write_data_in;
         end else if (wr_pc_high) begin
            pc_high_reg <= reg_write_data_in;
         end else if (pc_advance_in) begin
            // Carry from the low half into the high half
            {pc_high_reg, pc_low_reg} <= {pc_high_reg, pc_low_reg} + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Supported instruction check; only the two excluded opcodes are refused
   // Stop, wait, multiply and divide fall through to supported
   // The decoder must trap a refused opcode; nothing here stops execution
   // The flag is combinational so it is valid in the decode cycle itself
   // instruction support
   always_comb begin
      unique case (opcode_in)
         crs_pkg::OPC_FAST_SET, crs_pkg::OPC_SLOW_CLOCK: instr_supported_out = 1'b0;
         default: instr_supported_out = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; every one of them comes straight from a flip-flop
   // so no path runs from an input to these outputs
   // and the decoder may sample them at any point of the cycle
   assign accumulator_out = acc_reg;
   assign index_first_out = idx1_reg;
   assign index_second_out = idx2_reg;
   assign stack_pointer_out = sp_reg;
   assign program_counter_out = {pc_high_reg, pc_low_reg};
   assign core_mode_register_out = core_mode_reg;
   assign status_pop_out = status_pop_reg;
   assign status_pop_valid_out = status_pop_valid_reg;

endmodule : crs_register_set

// *** crs_mem_model.sv ***
// Stack memory seen on the far side of the register set.
// Assumes writes land at the clock edge and reads answer in the same cycle.
`timescale 1ns/1ps
module crs_mem_model (
   // Stack port from the register set
   input wire logic core_clk_in,
   input wire logic [15:0] stack_addr_in,
   input wire logic stack_write_in,
   input wire logic stack_read_in,
   input wire logic [7:0] stack_wdata_in,
   // Read data back to the register set
   output logic [7:0] mem_rdata_out
);
   logic [7:0] mem [0:511];
   logic [7:0] last_reg = 8'h5a;
   always @(posedge core_clk_in) begin
      if (stack_write_in) mem[stack_addr_in[8:0]] <= stack_wdata_in;
      if (stack_read_in) last_reg <= mem_rdata_out;
   end
   // Idle bus shows the inverse of the last byte, so stale data never passes
   assign mem_rdata_out = stack_read_in ? mem[stack_addr_in[8:0]] : ~last_reg;
endmodule : crs_mem_model

// *** crs_monitor.sv ***
// Checker on the register set ports, bound from the testbench top.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module crs_monitor (
   // Inputs of the register set
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   input wire logic reg_write_in,
   input wire logic pc_advance_in,
   input wire logic pc_load_in,
   input wire logic [15:0] pc_load_value_in,
   input wire logic [7:0] operand_in,
   input wire crs_pkg::crs_stack_op_t stack_op_in,
   input wire logic [7:0] mem_rdata_in,
   // Outputs of the register set
   input wire logic [7:0] accumulator_out,
   input wire logic [7:0] index_first_out,
   input wire logic [7:0] index_second_out,
   input wire logic [7:0] stack_pointer_out,
   input wire logic [15:0] program_counter_out,
   input wire logic [7:0] core_mode_register_out,
   input wire logic [15:0] index_first_addr_out,
   input wire logic [15:0] index_second_addr_out,
   input wire logic [15:0] stack_addr_out,
   input wire logic stack_write_out,
   input wire logic [7:0] stack_wdata_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   // Taken stack operations
   wire logic push_w = clk_en_in && stack_op_in == crs_pkg::CRS_STK_PUSH_ACC;
   wire logic pop_w = clk_en_in && stack_op_in == crs_pkg::CRS_STK_POP_ACC;
   wire logic [7:0] page_w = core_mode_register_out[crs_pkg::CORE_MODE_STACK_PAGE_BIT] ?
      crs_pkg::STACK_PAGE1_HIGH : crs_pkg::STACK_PAGE0_HIGH;
   sequence s_push_write;
      stack_write_out && stack_wdata_out == accumulator_out && stack_addr_out[7:0] == stack_pointer_out;
   endsequence
   sequence s_sp_down;
      stack_pointer_out == $past(stack_pointer_out) - 8'h01;
   endsequence
   property p_push;
      push_w |-> s_push_write ##1 s_sp_down;
   endproperty
   a_push: assert property (p_push) else $error("push write or pointer step wrong");
   property p_pop;
      pop_w |-> stack_addr_out[7:0] == stack_pointer_out + 8'h01 ##1
         accumulator_out == $past(mem_rdata_in) && stack_pointer_out == $past(stack_pointer_out) + 8'h01;
   endproperty
   a_pop: assert property (p_pop) else $error("pop address or result wrong");
   property p_page;
      push_w || pop_w |-> stack_addr_out[15:8] == page_w;
   endproperty
   a_page: assert property (p_page) else $error("stack page byte wrong");
   property p_idx1;
      index_first_addr_out == {7'h00, {1'b0, operand_in} + {1'b0, index_first_out}};
   endproperty
   a_idx1: assert property (p_idx1) else $error("first index address wrong");
   property p_idx2;
      index_second_addr_out == {7'h00, {1'b0, operand_in} + {1'b0, index_second_out}};
   endproperty
   a_idx2: assert property (p_idx2) else $error("second index address wrong");
   property p_adv;
      clk_en_in && pc_advance_in && !pc_load_in && !reg_write_in |=>
         program_counter_out == $past(program_counter_out) + 16'h0001;
   endproperty
   a_adv: assert property (p_adv) else $error("counter did not advance by one");
   property p_load;
      clk_en_in && pc_load_in |=> program_counter_out == $past(pc_load_value_in);
   endproperty
   a_load: assert property (p_load) else $error("counter load lost");
   property p_freeze;
      !clk_en_in |=> $stable(accumulator_out) && $stable(program_counter_out);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule : crs_monitor

// *** test_cpu_register_set_stack_addressing.sv ***
// Self-checking bench: register set, stack memory model and bound checker.
// Assumes the package, model and checker are compiled first.
`timescale 1ns/1ps
module test_cpu_register_set_stack_addressing;
   typedef struct {int k; logic [15:0] v;} crs_note_t;
   logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, rw = 1'b0, adv = 1'b0, ld = 1'b0, mw = 1'b0;
   logic [7:0] opnd = 8'h00, opc = 8'h00, wd = 8'h00, st = 8'h00, mwd = 8'h00, rd, a;
   logic [7:0] acc, x1, x2, sp, cm, swd, spo;
   logic [2:0] sel = 3'h0;
   logic [15:0] ldv = 16'h0000, ma = 16'h0000, pc, a1, a2, sa, r;
   logic sw, sr, pv, sup;
   crs_pkg::crs_stack_op_t sop = crs_pkg::CRS_STK_IDLE;
   logic [7:0] ev [0:5] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
   logic [7:0] ops [0:5] = '{crs_pkg::OPC_FAST_SET, crs_pkg::OPC_SLOW_CLOCK, crs_pkg::OPC_STOP_OSC,
      crs_pkg::OPC_WAIT, crs_pkg::OPC_MULTIPLY, crs_pkg::OPC_DIVIDE};
   int failures = 0, num_checks = 0, seed = 68, i, pg;
   crs_note_t q[$], n;
   crs_register_set dut (.core_clk_in(clk), .arst_n_in(rst_n), .clk_en_in(en), .operand_in(opnd),
      .opcode_in(opc), .pc_advance_in(adv), .pc_load_in(ld), .pc_load_value_in(ldv),
      .reg_write_in(rw), .reg_sel_in(sel), .reg_write_data_in(wd), .stack_op_in(sop),
      .status_in(st), .mem_addr_in(ma), .mem_write_in(mw), .mem_wdata_in(mwd), .mem_rdata_in(rd),
      .accumulator_out(acc), .index_first_out(x1), .index_second_out(x2), .stack_pointer_out(sp),
      .program_counter_out(pc), .core_mode_register_out(cm), .index_first_addr_out(a1),
      .index_second_addr_out(a2), .stack_addr_out(sa), .stack_write_out(sw),
      .stack_read_out(sr), .stack_wdata_out(swd), .status_pop_out(spo),
      .status_pop_valid_out(pv), .instr_supported_out(sup));
   crs_mem_model mem (.core_clk_in(clk), .stack_addr_in(sa), .stack_write_in(sw),
      .stack_read_in(sr), .stack_wdata_in(swd), .mem_rdata_out(rd));
   initial forever #12.5 clk = ~clk;
   task tick; @(posedge clk); endtask : tick
   task note(input int k, input logic [15:0] v); q.push_back('{k, v}); endtask : note
   // Strobe stays high so back-to-back writes never re-assign it in one step
   task wr(input logic [2:0] s, input logic [7:0] d);
      rw <= 1'b1;
      sel <= s;
      wd <= d;
      tick;
   endtask : wr
   task idle;
      rw <= 1'b0;
      mw <= 1'b0;
      adv <= 1'b0;
      ld <= 1'b0;
      sop <= crs_pkg::CRS_STK_IDLE;
      tick;
   endtask : idle
   task do_reset;
      rst_n <= 1'b0;
      repeat (5) tick;
      rst_n <= 1'b1;
      repeat (3) tick;
   endtask : do_reset
   task chk16(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk16
   task finish_test;
      if (failures == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   // Notes are compared at the falling edge, once registered outputs settle
   always @(negedge clk) begin
      while (q.size() > 0) begin
         n = q.pop_front();
         case (n.k)
            0: chk16({8'h00, acc}, n.v);
            1: chk16({8'h00, x1}, n.v);
            2: chk16({8'h00, x2}, n.v);
            6: chk16({8'h00, cm}, n.v);
            3: chk16({8'h00, sp}, n.v);
            4: chk16(pc, n.v);
            7: chk16(sa, n.v);
            8: chk16({7'h00, pv, spo}, n.v);
            default: chk16({15'h0000, sup}, n.v);
         endcase
      end
   end
   initial begin
      do_reset;
      note(0, 16'h0000);
      note(3, 16'h00ff);
      for (i = 0; i < 6; i++) begin
         a = 8'($random(seed));
         ev[i] = a;
         opnd <= 8'($random(seed));
         opc <= ops[i];
         note(9, {15'h0000, i > 1});
         wr(i[2:0], a);
         note(i < 4 ? i : 4, i < 4 ? {8'h00, ev[i]} : {ev[5], ev[4]});
      end
      idle;
      for (pg = 0; pg < 2; pg++) begin
         a = 8'($random(seed));
         mw <= 1'b1;
         ma <= crs_pkg::CORE_MODE_ADDR;
         mwd <= pg == 1 ? 8'h04 : 8'h00;
         wr(0, a);
         note(6, {8'h00, pg == 1 ? 8'h04 : 8'h00});
         wr(3, 8'h00);
         idle;
         st <= ~a;
         sop <= crs_pkg::CRS_STK_PUSH_ACC;
         note(7, {pg[7:0], 8'h00});
         tick;
         note(3, 16'h00ff);
         sop <= crs_pkg::CRS_STK_PUSH_STAT;
         tick;
         sop <= crs_pkg::CRS_STK_IDLE;
         wr(0, 8'h00);
         rw <= 1'b0;
         sop <= crs_pkg::CRS_STK_POP_STAT;
         note(7, {pg[7:0], 8'hff});
         tick;
         note(8, {8'h01, ~a});
         sop <= crs_pkg::CRS_STK_POP_ACC;
         tick;
         note(0, {8'h00, a});
         note(3, 16'h0000);
         idle;
      end
      wr(4, 8'hff);
      wr(5, 8'h12);
      rw <= 1'b0;
      adv <= 1'b1;
      tick;
      note(4, 16'h1300);
      r = 16'($random(seed));
      ld <= 1'b1;
      ldv <= r;
      tick;
      note(4, r);
      ld <= 1'b0;
      en <= 1'b0;
      wr(0, ~a);
      note(0, {8'h00, a});
      note(4, r);
      en <= 1'b1;
      idle;
      do_reset;
      note(3, 16'h00ff);
      note(4, 16'h0000);
      tick;
      finish_test;
   end
   // Whole run is well under a hundred cycles
   initial begin
      #20us;
      failures++;
      finish_test;
   end
endmodule : test_cpu_register_set_stack_addressing
bind crs_register_set crs_monitor u_mon (.core_clk_in, .arst_n_in, .clk_en_in, .reg_write_in,
   .pc_advance_in, .pc_load_in, .pc_load_value_in, .operand_in, .stack_op_in, .mem_rdata_in,
   .accumulator_out, .index_first_out, .index_second_out, .stack_pointer_out, .program_counter_out,
   .core_mode_register_out, .index_first_addr_out, .index_second_addr_out, .stack_addr_out,
   .stack_write_out, .stack_wdata_out);
